// >>> hw/mpc_device.sv
`timescale 1ns/1ps
module mpc_device #(
    parameter int unsigned START_CYC = mpc_pkg::START_PULSE_CYC,
    parameter int unsigned RESTART_CYC = mpc_pkg::RESTART_PULSE_CYC,
    parameter int unsigned OFF_CYC = mpc_pkg::SWITCH_OFF_CYC,
    parameter int unsigned SHDN_CYC = mpc_pkg::SHUTDOWN_CYC,
    parameter int unsigned BUSY_CYC = mpc_pkg::RESTART_BUSY_CYC,
    parameter int unsigned BOOT_CYC = mpc_pkg::INIT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    mpc_link_if.dev link,
    input wire logic supply_present,
    input wire logic limits_ok,
    input wire logic call_active,
    input wire logic usb_suspended_or_absent,
    input wire logic port_idle,
    input wire logic power_saving_en,
    input wire logic power_down_cmd,
    input wire logic func_restart_cmd,
    input wire logic airplane_cmd,
    input wire logic radio_cmd_req,
    output logic [2:0] power_mode,
    output logic airplane_mode,
    output logic radio_enabled,
    output logic radio_cmd_reject,
    output logic software_running,
    output logic rtc_regulator_on,
    output logic volatile_clear
);
    import mpc_pkg::*;

    // ------------------------------------------------------------
    // Line synchronisers
    // ------------------------------------------------------------
    logic ign_s1_q, ign_s2_q, rst_s1_q, rst_s2_q;
    // Two flops each; only the second stage is used downstream
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ign_s1_q <= 1'b1;
            ign_s2_q <= 1'b1;
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
        end else begin
            ign_s1_q <= link.ignition_line_n;
            ign_s2_q <= ign_s1_q;
            rst_s1_q <= link.emergency_restart_line_n;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire ign_low = ~ign_s2_q;
    wire rst_low = ~rst_s2_q;

    // ------------------------------------------------------------
    // Low-duration counters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] ign_cnt_q, rst_cnt_q, rst_arm_cnt_q, tmr_q;
    logic rst_armed_q;
    mpc_state_type st_q, st_d;
    // Counters saturate so a grounded line never wraps
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ign_cnt_q <= CNT_ZERO;
            rst_cnt_q <= CNT_ZERO;
        end else begin
            ign_cnt_q <= !ign_low ? CNT_ZERO :
                (ign_cnt_q == CNT_W'(START_CYC)) ? ign_cnt_q :
                ign_cnt_q + CNT_ONE;
            rst_cnt_q <= !rst_low ? CNT_ZERO :
                (rst_cnt_q == CNT_W'(OFF_CYC)) ? rst_cnt_q :
                rst_cnt_q + CNT_ONE;
        end
    end

    // Arm counter: restart timing restarts after each reset cycle
    wire start_hit = ign_low && ign_cnt_q == CNT_W'(START_CYC);
    wire off_hit = rst_cnt_q == CNT_W'(OFF_CYC);
    wire restart_hit = rst_armed_q && rst_low &&
        rst_arm_cnt_q == CNT_W'(RESTART_CYC);
    wire running = st_q == ST_INIT || st_q == ST_IDLE ||
        st_q == ST_SLEEP || st_q == ST_ACTIVE;
    wire reset_done = st_q == ST_RESET && tmr_q == CNT_W'(BUSY_CYC);

    // After a restart the arm flag drops; reset_done or the line going high re-arms it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_armed_q <= 1'b1;
            rst_arm_cnt_q <= CNT_ZERO;
        end else begin
            if (!rst_low)
                rst_armed_q <= 1'b1;
            else if (reset_done)
                rst_armed_q <= 1'b1;
            else if (restart_hit)
                rst_armed_q <= 1'b0;
            rst_arm_cnt_q <= (!rst_low || !rst_armed_q || restart_hit) ?
                CNT_ZERO : rst_arm_cnt_q + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    wire ready_mode = st_q == ST_IDLE || st_q == ST_SLEEP ||
        st_q == ST_ACTIVE;
    wire want_sleep = !call_active && usb_suspended_or_absent &&
        port_idle && power_saving_en;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_OFF: if (supply_present && start_hit)
                st_d = ST_RESET;
            ST_RESET: if (reset_done)
                st_d = ST_INIT;
            ST_INIT: if (tmr_q == CNT_W'(BOOT_CYC))
                st_d = ST_IDLE;
            ST_IDLE, ST_SLEEP, ST_ACTIVE: begin
                if (call_active)
                    st_d = ST_ACTIVE;
                else if (want_sleep)
                    st_d = ST_SLEEP;
                else
                    st_d = ST_IDLE;
                if (power_down_cmd)
                    st_d = ST_SHUTDOWN;
            end
            ST_SHUTDOWN: if (tmr_q == CNT_W'(SHDN_CYC))
                st_d = ST_OFF;
            default: st_d = ST_OFF;
        endcase
        if (running && (restart_hit || func_restart_cmd))
            st_d = ST_RESET;
        if (st_q == ST_RESET && restart_hit)
            st_d = ST_RESET;
        if (st_q != ST_OFF && !limits_ok)
            st_d = ST_OFF;
        if (off_hit || !supply_present)
            st_d = ST_OFF;
    end

    // Phase timer clears on every state change
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_OFF;
            tmr_q <= CNT_ZERO;
        end else begin
            st_q <= st_d;
            tmr_q <= (st_d != st_q || (st_q == ST_RESET && restart_hit)) ?
                CNT_ZERO : tmr_q + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire [2:0] mode_d =
        (st_d == ST_OFF) ? MODE_OFF :
        (st_d == ST_RESET || st_d == ST_INIT) ? MODE_RESET :
        (st_d == ST_SLEEP) ? MODE_SLEEP :
        (st_d == ST_ACTIVE) ? MODE_ACTIVE :
        (st_d == ST_SHUTDOWN) ? MODE_SHUTDOWN : MODE_IDLE;
    wire ready_d = st_d == ST_IDLE || st_d == ST_SLEEP ||
        st_d == ST_ACTIVE;
    wire air_d = ready_mode ? airplane_cmd : 1'b0;
    // Reject uses the same next-state view, so no cycle slips through
    wire radio_d = ready_d && !air_d;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            power_mode <= MODE_OFF;
            airplane_mode <= 1'b0;
            radio_enabled <= 1'b0;
            radio_cmd_reject <= 1'b0;
            software_running <= 1'b0;
            rtc_regulator_on <= 1'b0;
            volatile_clear <= 1'b0;
            link.primary_clear_to_send_n <= 1'b1;
            link.primary_data_set_ready_n <= 1'b1;
            link.primary_ring_indicator_n <= 1'b1;
            link.low_volt_supply_output <= 1'b0;
        end else begin
            power_mode <= mode_d;
            airplane_mode <= air_d && ready_d;
            radio_enabled <= radio_d;
            radio_cmd_reject <= radio_cmd_req && !radio_d;
            software_running <= st_d != ST_OFF && st_d != ST_RESET;
            rtc_regulator_on <= supply_present;
            volatile_clear <= st_d == ST_RESET;
            link.primary_clear_to_send_n <= !ready_d;
            link.primary_data_set_ready_n <= !ready_d;
            link.primary_ring_indicator_n <= !ready_d;
            link.low_volt_supply_output <= st_d != ST_OFF;
        end
    end
endmodule : mpc_device

// >>> hw/mpc_host.sv
`timescale 1ns/1ps
module mpc_host #(
    parameter int unsigned START_CYC = mpc_pkg::START_PULSE_CYC,
    parameter int unsigned RESTART_CYC = mpc_pkg::RESTART_PULSE_CYC,
    parameter int unsigned WAIT_CYC = mpc_pkg::HOST_WAIT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    mpc_link_if.host link,
    input wire logic power_on_req,
    input wire logic restart_req,
    input wire logic hold_restart,
    input wire logic unresponsive,
    output logic busy,
    output logic device_ready,
    output logic device_powered
);
    import mpc_pkg::*;

    // ------------------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------------------
    logic [CNT_W-1:0] ign_cnt_q, rst_cnt_q, hang_cnt_q;
    logic ign_q, rst_q;
    // Ignition pulled low straight from reset as a pulse, released once ign_done is reached
    wire ign_done = ign_cnt_q == CNT_W'(START_CYC + 1);
    wire hung = hang_cnt_q == CNT_W'(WAIT_CYC + 1);
    wire rst_go = restart_req && hung && !rst_q;
    // Low time saturates, so a line held past the pulse still lets go
    wire rst_full = rst_cnt_q == CNT_W'(RESTART_CYC + 1);
    wire rst_done = rst_full && !hold_restart;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ign_q <= 1'b1;
            ign_cnt_q <= CNT_ZERO;
        end else begin
            ign_q <= power_on_req ? 1'b1 : !ign_done;
            ign_cnt_q <= power_on_req ? CNT_ZERO :
                ign_done ? ign_cnt_q : ign_cnt_q + CNT_ONE;
        end
    end

    // Restart drive counts low time; unresponsive time gates it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 1'b0;
            rst_cnt_q <= CNT_ZERO;
            hang_cnt_q <= CNT_ZERO;
        end else begin
            rst_q <= rst_go ? 1'b1 : rst_done ? 1'b0 : rst_q;
            rst_cnt_q <= !rst_q ? CNT_ZERO :
                rst_full ? rst_cnt_q : rst_cnt_q + CNT_ONE;
            hang_cnt_q <= !unresponsive ? CNT_ZERO :
                hung ? hang_cnt_q : hang_cnt_q + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.ignition_line_n <= 1'b0;
            link.emergency_restart_line_n_o <= 1'b0;
            link.emergency_restart_line_n_oe <= 1'b0;
            busy <= 1'b0;
            device_ready <= 1'b0;
            device_powered <= 1'b0;
        end else begin
            link.ignition_line_n <= !ign_q;
            link.emergency_restart_line_n_o <= 1'b0;
            link.emergency_restart_line_n_oe <= rst_q;
            busy <= rst_q || ign_q;
            device_ready <= !link.primary_clear_to_send_n &&
                !link.primary_data_set_ready_n;
            device_powered <= link.low_volt_supply_output;
        end
    end
endmodule : mpc_host

// >>> hw/mpc_link_if.sv
`timescale 1ns/1ps
interface mpc_link_if;
    logic ignition_line_n;
    logic emergency_restart_line_n_o;
    logic emergency_restart_line_n_oe;
    logic emergency_restart_line_n;
    logic primary_clear_to_send_n;
    logic primary_data_set_ready_n;
    logic primary_ring_indicator_n;
    logic low_volt_supply_output;
    // Open-drain restart line: pulled up unless driven low
    assign emergency_restart_line_n =
        emergency_restart_line_n_oe ? emergency_restart_line_n_o : 1'b1;
    modport dev (
        input ignition_line_n,
        input emergency_restart_line_n,
        output primary_clear_to_send_n,
        output primary_data_set_ready_n,
        output primary_ring_indicator_n,
        output low_volt_supply_output
    );
    modport host (
        output ignition_line_n,
        output emergency_restart_line_n_o,
        output emergency_restart_line_n_oe,
        input emergency_restart_line_n,
        input primary_clear_to_send_n,
        input primary_data_set_ready_n,
        input primary_ring_indicator_n,
        input low_volt_supply_output
    );
endinterface : mpc_link_if

// >>> hw/mpc_pkg.sv
package mpc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned START_PULSE_MS = 300;
    localparam int unsigned RESTART_PULSE_MS = 200;
    localparam int unsigned SWITCH_OFF_MS = 8000;
    localparam int unsigned HOST_WAIT_MS = 5000;
    localparam int unsigned SHUTDOWN_MS = 2000;
    localparam int unsigned RESTART_BUSY_US = 100;
    localparam int unsigned INIT_US = 100;
    localparam int unsigned START_PULSE_CYC = START_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESTART_PULSE_CYC =
        RESTART_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned SWITCH_OFF_CYC = SWITCH_OFF_MS * 1000 * CLK_MHZ;
    localparam int unsigned HOST_WAIT_CYC = HOST_WAIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESTART_BUSY_CYC = RESTART_BUSY_US * CLK_MHZ;
    localparam int unsigned INIT_CYC = INIT_US * CLK_MHZ;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

    // ------------------------------------------------------------
    // Device power states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_RESET = 7'h02,
        ST_INIT = 7'h04,
        ST_IDLE = 7'h08,
        ST_SLEEP = 7'h10,
        ST_ACTIVE = 7'h20,
        ST_SHUTDOWN = 7'h40
    } mpc_state_type;

    // Reported mode code
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_RESET = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h2;
    localparam logic [2:0] MODE_SLEEP = 3'h3;
    localparam logic [2:0] MODE_ACTIVE = 3'h4;
    localparam logic [2:0] MODE_SHUTDOWN = 3'h5;
endpackage : mpc_pkg

// >>> tb/mpc_link_properties.sv
`timescale 1ns/1ps
// Checker beside the link: sees only the wires between the two ends
module mpc_link_properties #(
    parameter int unsigned START_CYC = 20,
    parameter int unsigned RESTART_CYC = 10,
    parameter int unsigned OFF_CYC = 200,
    parameter int BOOT_MAX = 30
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ignition_line_n,
    input wire logic emergency_restart_line_n_o,
    input wire logic emergency_restart_line_n_oe,
    input wire logic emergency_restart_line_n,
    input wire logic primary_clear_to_send_n,
    input wire logic primary_data_set_ready_n,
    input wire logic primary_ring_indicator_n,
    input wire logic low_volt_supply_output
);
    localparam int REP_MAX = RESTART_CYC + 8;
    logic [31:0] ign_cnt_q, ign_cnt_d, rst_cnt_q, rst_cnt_d;
    logic ign_long_q, ign_long_d;

    // ------------------------------------------------------------
    // Low-time counters
    // ------------------------------------------------------------
    // Slack of one cycle covers the device's input synchroniser
    assign ign_cnt_d = ignition_line_n ? 32'h0 : ign_cnt_q + 32'h1;
    assign rst_cnt_d = emergency_restart_line_n ? 32'h0 : rst_cnt_q + 32'h1;
    assign ign_long_d = (ign_cnt_q >= START_CYC - 1) ? 1'b1 :
        (low_volt_supply_output ? 1'b0 : ign_long_q);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ign_cnt_q <= 32'h0;
            rst_cnt_q <= 32'h0;
            ign_long_q <= 1'b0;
        end else begin
            ign_cnt_q <= ign_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            ign_long_q <= ign_long_d;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_host_open_drain: assert property (
        emergency_restart_line_n_oe |-> !emergency_restart_line_n_o)
        else $error("restart line driven high");
    a_ready_lines_paired: assert property (
        $fell(primary_clear_to_send_n) |->
        !primary_data_set_ready_n && !primary_ring_indicator_n)
        else $error("ready lines not together");
    a_ready_needs_power: assert property (
        !primary_clear_to_send_n |-> low_volt_supply_output)
        else $error("ready while powered down");
    a_off_ports_high: assert property (
        !low_volt_supply_output |-> primary_clear_to_send_n &&
        primary_data_set_ready_n && primary_ring_indicator_n)
        else $error("port line low in power down");
    a_start_pulse_width: assert property (
        $rose(low_volt_supply_output) |-> ign_long_q)
        else $error("started on short ignition pulse");
    a_long_hold_off: assert property (
        rst_cnt_q == OFF_CYC + 6 |-> !low_volt_supply_output)
        else $error("no switch-off after long hold");
    a_restart_resets_ports: assert property (
        rst_cnt_q == RESTART_CYC + 6 && low_volt_supply_output
        |-> primary_clear_to_send_n)
        else $error("restart did not reset port lines");
    a_restart_repeats: assert property (
        $fell(primary_clear_to_send_n) && !emergency_restart_line_n &&
        rst_cnt_q < OFF_CYC |-> ##[1:REP_MAX] primary_clear_to_send_n)
        else $error("held restart did not repeat");
    a_ready_after_start: assert property (
        $rose(low_volt_supply_output) |-> ##[1:BOOT_MAX]
        (!primary_clear_to_send_n || !low_volt_supply_output))
        else $error("ready lines late after start");
endmodule : mpc_link_properties

// >>> tb/mpc_tb.sv
`timescale 1ns/1ps
// Bench: host and device ends joined through the link
module mpc_tb;
    import mpc_pkg::*;
    logic core_clk, nrst, supply_present, limits_ok, call_active;
    logic usb_suspended_or_absent, port_idle, power_saving_en;
    logic power_down_cmd, func_restart_cmd, airplane_cmd, radio_cmd_req;
    logic power_on_req, restart_req, hold_restart, unresponsive;
    logic [2:0] power_mode;
    logic airplane_mode, radio_enabled, radio_cmd_reject, software_running;
    logic rtc_regulator_on, volatile_clear, busy, device_ready;
    logic device_powered;
    int n_fail = 0;
    int num_checks = 0;

    // Short counts keep the whole run to a few hundred cycles
    localparam int unsigned T_START = 20;
    localparam int unsigned T_RESTART = 10;
    localparam int unsigned T_OFF = 200;
    localparam int unsigned T_SHDN = 30;
    localparam int unsigned T_BUSY = 5;
    localparam int unsigned T_BOOT = 5;
    localparam int unsigned T_WAIT = 8;
    localparam int T_BOOT_MAX = 30;

    mpc_link_if mpc_link_if_i();
    mpc_device #(.START_CYC(T_START), .RESTART_CYC(T_RESTART),
        .OFF_CYC(T_OFF), .SHDN_CYC(T_SHDN), .BUSY_CYC(T_BUSY),
        .BOOT_CYC(T_BOOT)) mpc_device_i (
        .core_clk, .nrst, .link(mpc_link_if_i), .supply_present,
        .limits_ok, .call_active, .usb_suspended_or_absent, .port_idle,
        .power_saving_en, .power_down_cmd, .func_restart_cmd,
        .airplane_cmd, .radio_cmd_req, .power_mode, .airplane_mode,
        .radio_enabled, .radio_cmd_reject, .software_running,
        .rtc_regulator_on, .volatile_clear);
    mpc_host #(.START_CYC(T_START), .RESTART_CYC(T_RESTART),
        .WAIT_CYC(T_WAIT)) mpc_host_i (
        .core_clk, .nrst, .link(mpc_link_if_i), .power_on_req,
        .restart_req, .hold_restart, .unresponsive, .busy, .device_ready,
        .device_powered);
    mpc_link_properties #(.START_CYC(T_START), .RESTART_CYC(T_RESTART),
        .OFF_CYC(T_OFF), .BOOT_MAX(T_BOOT_MAX)) mpc_link_properties_i (
        .core_clk, .nrst,
        .ignition_line_n(mpc_link_if_i.ignition_line_n),
        .emergency_restart_line_n_o(mpc_link_if_i.emergency_restart_line_n_o),
        .emergency_restart_line_n_oe(
            mpc_link_if_i.emergency_restart_line_n_oe),
        .emergency_restart_line_n(mpc_link_if_i.emergency_restart_line_n),
        .primary_clear_to_send_n(mpc_link_if_i.primary_clear_to_send_n),
        .primary_data_set_ready_n(mpc_link_if_i.primary_data_set_ready_n),
        .primary_ring_indicator_n(mpc_link_if_i.primary_ring_indicator_n),
        .low_volt_supply_output(mpc_link_if_i.low_volt_supply_output));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [2:0] got, input logic [2:0] exp,
            input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : chk

    // Bounded wait; running out of cycles shows up as a mismatch
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int i;
        i = 0;
        while (power_mode !== m && i < lim) begin
            @(negedge core_clk);
            i++;
        end
        chk(power_mode, m, "mode not reached");
    endtask : wait_mode

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_power_on();
        wait_mode(MODE_IDLE, 200);
        cyc(2);
        chk(mpc_link_if_i.primary_clear_to_send_n, 1'b0, "not ready");
        chk({device_ready, software_running, rtc_regulator_on}, 3'h7,
            "not up");
        chk(device_powered, 1'b1, "supply output not seen");
        chk(busy, 1'b0, "ignition pulse not ended");
    endtask : s_power_on

    task automatic s_modes();
        power_saving_en = 1'b1;
        wait_mode(MODE_SLEEP, 20);
        port_idle = 1'b0;
        wait_mode(MODE_IDLE, 20);
        port_idle = 1'b1;
        usb_suspended_or_absent = 1'b0;
        cyc(10);
        chk(power_mode, MODE_IDLE, "slept with usb up");
        usb_suspended_or_absent = 1'b1;
        call_active = 1'b1;
        wait_mode(MODE_ACTIVE, 20);
        call_active = 1'b0;
        power_saving_en = 1'b0;
        wait_mode(MODE_IDLE, 20);
    endtask : s_modes

    task automatic s_airplane();
        airplane_cmd = 1'b1;
        radio_cmd_req = 1'b1;
        cyc(5);
        chk({airplane_mode, radio_enabled, radio_cmd_reject}, 3'h5,
            "airplane");
        airplane_cmd = 1'b0;
        cyc(5);
        chk({airplane_mode, radio_enabled, radio_cmd_reject}, 3'h2,
            "radio back");
        radio_cmd_req = 1'b0;
    endtask : s_airplane

    task automatic s_func_restart();
        func_restart_cmd = 1'b1;
        cyc(1);
        func_restart_cmd = 1'b0;
        wait_mode(MODE_RESET, 10);
        wait_mode(MODE_IDLE, 60);
    endtask : s_func_restart

    task automatic s_emerg();
        restart_req = 1'b1;
        cyc(30);
        chk(mpc_link_if_i.emergency_restart_line_n_oe, 1'b0,
            "restart while responsive");
        unresponsive = 1'b1;
        wait_mode(MODE_RESET, 100);
        chk({volatile_clear, mpc_link_if_i.primary_clear_to_send_n}, 3'h3,
            "state kept");
        restart_req = 1'b0;
        unresponsive = 1'b0;
        wait_mode(MODE_IDLE, 200);
    endtask : s_emerg

    // Hold the restart line: repeated restarts, then switch-off
    task automatic s_long_hold();
        int n;
        int i;
        logic [2:0] prev;
        n = 0;
        i = 0;
        prev = power_mode;
        unresponsive = 1'b1;
        restart_req = 1'b1;
        hold_restart = 1'b1;
        while (power_mode !== MODE_OFF && i < 400) begin
            @(negedge core_clk);
            if (power_mode === MODE_RESET && prev !== MODE_RESET) n++;
            prev = power_mode;
            i++;
        end
        chk(power_mode, MODE_OFF, "no switch-off");
        chk(n > 2, 1'b1, "no repeated restart");
        chk(busy, 1'b1, "restart line let go while held");
        hold_restart = 1'b0;
        restart_req = 1'b0;
        unresponsive = 1'b0;
        cyc(40);
        chk(mpc_link_if_i.emergency_restart_line_n, 1'b1,
            "restart line stuck low");
        chk(power_mode, MODE_OFF, "woke without ignition");
        chk(mpc_link_if_i.low_volt_supply_output, 1'b0,
            "supply output after switch-off");
    endtask : s_long_hold

    task automatic s_limits();
        limits_ok = 1'b0;
        power_on_req = 1'b1;
        cyc(1);
        power_on_req = 1'b0;
        cyc(120);
        chk(power_mode, MODE_OFF, "ran out of limits");
        chk(device_ready, 1'b0, "ready out of limits");
        limits_ok = 1'b1;
    endtask : s_limits

    task automatic s_power_down();
        int n;
        n = 0;
        power_on_req = 1'b1;
        cyc(1);
        power_on_req = 1'b0;
        wait_mode(MODE_IDLE, 200);
        power_down_cmd = 1'b1;
        cyc(1);
        power_down_cmd = 1'b0;
        wait_mode(MODE_SHUTDOWN, 10);
        while (power_mode === MODE_SHUTDOWN && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        chk(n == T_SHDN + 1, 1'b1, "shutdown length");
        chk({mpc_link_if_i.low_volt_supply_output, software_running,
            rtc_regulator_on}, 3'h1, "power down state");
    endtask : s_power_down

    // Ignition without supply must not start the device
    task automatic s_no_supply();
        supply_present = 1'b0;
        power_on_req = 1'b1;
        cyc(1);
        power_on_req = 1'b0;
        cyc(40);
        chk(power_mode, MODE_OFF, "started without supply");
        chk({device_powered, rtc_regulator_on}, 3'h0, "rtc rail on");
        supply_present = 1'b1;
        cyc(5);
        chk(rtc_regulator_on, 1'b1, "rtc rail off");
        chk(power_mode, MODE_OFF, "started on supply return");
    endtask : s_no_supply

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        {nrst, call_active, power_saving_en, power_down_cmd} = 4'h0;
        {func_restart_cmd, airplane_cmd, radio_cmd_req} = 3'h0;
        {power_on_req, restart_req, hold_restart, unresponsive} = 4'h0;
        {supply_present, limits_ok, usb_suspended_or_absent} = 3'h7;
        port_idle = 1'b1;
        cyc(10);
        nrst = 1'b1;
        s_power_on();
        s_modes();
        s_airplane();
        s_func_restart();
        s_emerg();
        s_long_hold();
        s_limits();
        s_power_down();
        s_no_supply();
        print_verdict();
    end
endmodule : mpc_tb
